// ==== core/bcsi_defines.vh ====
/*
 Constants for the brake chopper status indicator block: register byte offsets,
 field positions, reset values, restore pattern and lamp timing.
 Assumes inclusion by bare name from the design files under core/.
*/
`ifndef BCSI_DEFINES_VH
`define BCSI_DEFINES_VH

// Register byte offsets (one aligned 32-bit word each)
`define BCSI_OFS_CTRL        8'h00
`define BCSI_OFS_COND        8'h04
`define BCSI_OFS_LAMPS       8'h08
`define BCSI_OFS_IRQ_STAT    8'h0C
`define BCSI_OFS_IRQ_MASK    8'h10
`define BCSI_OFS_RESTORE     8'h14
`define BCSI_OFS_AMB_TEMP    8'h18
`define BCSI_OFS_THERM_RES   8'h1C
`define BCSI_OFS_TIME_CONST  8'h20
`define BCSI_OFS_PD_STATUS   8'h24

// Control register fields
`define BCSI_CTRL_STATE_LSB  0
`define BCSI_CTRL_STATE_W    3
`define BCSI_CTRL_CHOP_REQ   4

// Condition input bit positions (also interrupt bit positions)
`define BCSI_C_SUP_HIGH      0
`define BCSI_C_SUP_LOW       1
`define BCSI_C_SUP_ABSENT    2
`define BCSI_C_BOARD_HOT     3
`define BCSI_C_RES_WARN      4
`define BCSI_C_RES_HOT       5
`define BCSI_C_CHOP_ON       6
`define BCSI_NCOND           7

// Fieldbus slave state codes
`define BCSI_ST_INIT         3'h1
`define BCSI_ST_PREOP        3'h2
`define BCSI_ST_BOOT         3'h3
`define BCSI_ST_SAFEOP       3'h4
`define BCSI_ST_OP           3'h0

// Reported process data values in OP
`define BCSI_PD_STATE_OP     8'h08
`define BCSI_PD_WCNT_OK      8'h00

// Restore-defaults pattern
`define BCSI_RESTORE_PAT     32'h64616F6C

// Parameter reset values (plain defaults)
`define BCSI_RST_AMB_TEMP    16'h0019
`define BCSI_RST_THERM_RES   16'h0514
`define BCSI_RST_TIME_CONST  16'h0226

// Lamp timing: base tick period in ns, and patterns in ticks of 50 ms
`define BCSI_TICK_NS         50000000
`define BCSI_CLK_NS          8
`define BCSI_TICK_CYC        (`BCSI_TICK_NS / `BCSI_CLK_NS)
`define BCSI_FLASH_TICKS     4
`define BCSI_SINGLE_ON       4
`define BCSI_SINGLE_PERIOD   20

`endif

// ==== core/bcsi_top.v ====
/*
 Brake chopper status indicator block with AXI4-Lite register slave.
 Drives the run lamp from the fieldbus slave state and the condition lamps
 from measured condition flags; holds thermal model parameters and the
 restore-defaults command; raises a masked sticky-event interrupt.
 Assumes condition flags arrive from the analogue side asynchronously and
 that software writes the slave state into the control register.
*/
// How it works
// - Run lamp pattern encodes slave state
// - SAFEOP forces chopper drive off
// - Process data only valid in OP
// - Supply-good lamp only when all fine except resistor warning
// - Supply-good off on supply/thermal faults
// - Overvoltage lamp follows supply-high flag
// - Board temperature lamp follows board flag
// - Undervoltage lamp on low supply
// - Resistor warning lamp on squared-time limit
// - Chopper lamp while resistor switched on
// - Error with undervoltage when supply absent
// - Error with warning, overvoltage on resistor overtemperature
// - Restore pattern reverts all parameters
// - OP reports state 8, counter 0
// - Ambient temperature parameter held
// - Thermal resistance parameter held
// - Thermal time constant parameter held
`timescale 1ns/1ps
`include "bcsi_defines.vh"

module bcsi_top #(
   parameter TICK_CYC = `BCSI_TICK_CYC     // Cycles per 50 ms lamp tick
) (
   // Clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // AXI4-Lite write address
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   // AXI4-Lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   // AXI4-Lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read address
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   // AXI4-Lite read data
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Asynchronous condition flags from the measurement side
   input  wire        supply_high,
   input  wire        supply_low,
   input  wire        supply_absent,
   input  wire        board_hot,
   input  wire        current_squared_time_limit,
   input  wire        resistor_hot,
   input  wire        chopper_switched,
   // Lamps
   output reg         lamp_run,
   output reg         lamp_supply_ok,
   output reg         lamp_overvolt,
   output reg         lamp_board_temp,
   output reg         lamp_undervolt,
   output reg         lamp_res_warn,
   output reg         lamp_chopper,
   output reg         lamp_error,
   // Chopper drive request, process data gate and restore notice
   output reg         chopper_drive,
   output reg         pd_exchange_en,
   output reg         params_restored,
   // Interrupt
   output reg         irq
);

   // One-hot run lamp pattern states
   localparam [4:0] PAT_DARK   = 5'h01;
   localparam [4:0] PAT_FLASH  = 5'h02;
   localparam [4:0] PAT_SINGLE = 5'h04;
   localparam [4:0] PAT_STEADY = 5'h08;
   localparam [4:0] PAT_FLICK  = 5'h10;

   localparam NC = `BCSI_NCOND;

   // Raw flags gathered into a vector, position per defines
   wire [NC-1:0] cond_raw;
   assign cond_raw = {chopper_switched, resistor_hot, current_squared_time_limit,
                      board_hot, supply_absent, supply_low, supply_high};

   // Three-stage synchronisers; stage 1 feeds only stage 2
   reg  [NC-1:0] sync1_q;
   reg  [NC-1:0] sync2_q;
   reg  [NC-1:0] sync3_q;
   reg  [NC-1:0] cond_q;              // Filtered condition levels
   reg  [NC-1:0] cond_d;

   // Software state
   reg  [`BCSI_CTRL_STATE_W-1:0] slave_state_q;  // Fieldbus slave state
   reg           chop_req_q;          // Process data chopper request
   reg  [15:0]   amb_temp_q;          // Resistor ambient temperature, degC
   reg  [15:0]   therm_res_q;         // Thermal resistance, mdegC/W
   reg  [15:0]   time_const_q;        // Thermal time constant, s
   reg  [NC-1:0] irq_stat_q;          // Sticky event bits
   reg  [NC-1:0] irq_mask_q;          // One enables the event
   reg  [NC-1:0] cond_prev_q;         // For rising-edge events

   // Prescaler and pattern counters
   reg  [31:0]   presc_q;             // Free-running tick prescaler
   reg           tick_q;              // One-cycle 50 ms tick
   reg  [7:0]    tick_cnt_q;          // Tick counter for slow patterns
   reg  [2:0]    flash_cnt_q;         // Tick counter for even flashing
   reg  [3:0]    flick_cnt_q;         // Fast counter for flicker
   reg  [4:0]    pat_q;               // Current run lamp pattern

   // AXI bookkeeping
   reg           aw_held_q;           // Write address taken
   reg           w_held_q;            // Write data taken
   reg  [7:0]    awaddr_q;
   reg  [31:0]   wdata_q;
   reg  [3:0]    wstrb_q;

   // Byte-lane merge of a write into a 16-bit parameter
   function [15:0] merge16;
      input [15:0] old;
      input [31:0] data;
      input [3:0]  strb;
      begin
         merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
      end
   endfunction

   // Run lamp pattern from slave state
   function [4:0] state_pattern;
      input [`BCSI_CTRL_STATE_W-1:0] st;
      begin
         case (st)
            `BCSI_ST_INIT:   state_pattern = PAT_DARK;
            `BCSI_ST_PREOP:  state_pattern = PAT_FLASH;
            `BCSI_ST_SAFEOP: state_pattern = PAT_SINGLE;
            `BCSI_ST_OP:     state_pattern = PAT_STEADY;
            `BCSI_ST_BOOT:   state_pattern = PAT_FLICK;
            default:         state_pattern = PAT_DARK;
         endcase
      end
   endfunction

   wire wr_go;                        // Both halves of a write are present
   assign wr_go = aw_held_q & w_held_q & ~s_axi_bvalid;
   wire [NC-1:0] events;              // Rising edges of filtered conditions
   assign events = cond_q & ~cond_prev_q;
   wire in_op;
   assign in_op = (slave_state_q == `BCSI_ST_OP);
   wire restore_hit;                  // Full-word write of the restore pattern
   assign restore_hit = wr_go & (awaddr_q == `BCSI_OFS_RESTORE) & (wstrb_q == 4'hF) &
                        (wdata_q == `BCSI_RESTORE_PAT);

   // Synchroniser chain and agreement filter
   always @* begin
      cond_d = cond_q;
      if (sync2_q == sync3_q)
         cond_d = sync3_q;
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         sync1_q     <= {NC{1'b0}};
         sync2_q     <= {NC{1'b0}};
         sync3_q     <= {NC{1'b0}};
         cond_q      <= {NC{1'b0}};
         cond_prev_q <= {NC{1'b0}};
      end else begin
         sync1_q     <= cond_raw;
         sync2_q     <= sync1_q;
         sync3_q     <= sync2_q;
         cond_q      <= cond_d;
         cond_prev_q <= cond_q;
      end
   end

   // Free-running prescaler; period is a parameter so simulation can shorten it
   // prescaled pattern counter
   always @(posedge aclk) begin
      if (!aresetn) begin
         presc_q     <= 32'h00000000;
         tick_q      <= 1'b0;
         tick_cnt_q  <= 8'h00;
         flash_cnt_q <= 3'h0;
         flick_cnt_q <= 4'h0;
      end else begin
         tick_q      <= 1'b0;
         flick_cnt_q <= flick_cnt_q + 4'h1;
         if (presc_q >= TICK_CYC - 1) begin
            presc_q <= 32'h00000000;
            tick_q  <= 1'b1;
         end else begin
            presc_q <= presc_q + 32'h00000001;
         end
         if (tick_q) begin
            if (tick_cnt_q >= `BCSI_SINGLE_PERIOD - 1)
               tick_cnt_q <= 8'h00;
            else
               tick_cnt_q <= tick_cnt_q + 8'h01;
            // Own count keeps flash on and off equal across the slow wrap
            if (flash_cnt_q >= 2 * `BCSI_FLASH_TICKS - 1)
               flash_cnt_q <= 3'h0;
            else
               flash_cnt_q <= flash_cnt_q + 3'h1;
         end
      end
   end

   // Lamp, drive and interrupt outputs, all registered
   // registered lamps, dark in reset
   always @(posedge aclk) begin
      if (!aresetn) begin
         pat_q           <= PAT_DARK;
         lamp_run        <= 1'b0;
         lamp_supply_ok  <= 1'b0;
         lamp_overvolt   <= 1'b0;
         lamp_board_temp <= 1'b0;
         lamp_undervolt  <= 1'b0;
         lamp_res_warn   <= 1'b0;
         lamp_chopper    <= 1'b0;
         lamp_error      <= 1'b0;
         chopper_drive   <= 1'b0;
         pd_exchange_en  <= 1'b0;
         irq             <= 1'b0;
      end else begin
         pat_q <= state_pattern(slave_state_q);
         case (pat_q)
            PAT_DARK:   lamp_run <= 1'b0;
            PAT_FLASH:  lamp_run <= flash_cnt_q < `BCSI_FLASH_TICKS;
            PAT_SINGLE: lamp_run <= tick_cnt_q < `BCSI_SINGLE_ON;
            PAT_STEADY: lamp_run <= 1'b1;
            PAT_FLICK:  lamp_run <= flick_cnt_q[3];
            default:    lamp_run <= 1'b0;
         endcase
         lamp_supply_ok  <= ~(cond_q[`BCSI_C_SUP_HIGH] | cond_q[`BCSI_C_SUP_LOW] |
                              cond_q[`BCSI_C_SUP_ABSENT] | cond_q[`BCSI_C_RES_HOT] |
                              cond_q[`BCSI_C_BOARD_HOT]);
         lamp_overvolt   <= cond_q[`BCSI_C_SUP_HIGH] | cond_q[`BCSI_C_RES_HOT];
         lamp_board_temp <= cond_q[`BCSI_C_BOARD_HOT];
         lamp_undervolt  <= cond_q[`BCSI_C_SUP_LOW] | cond_q[`BCSI_C_SUP_ABSENT];
         lamp_res_warn   <= cond_q[`BCSI_C_RES_WARN] | cond_q[`BCSI_C_RES_HOT];
         lamp_chopper    <= cond_q[`BCSI_C_CHOP_ON];
         lamp_error      <= cond_q[`BCSI_C_SUP_ABSENT] | cond_q[`BCSI_C_RES_HOT];
         chopper_drive   <= chop_req_q & in_op;
         pd_exchange_en  <= in_op;
         irq             <= |(irq_stat_q & irq_mask_q);
      end
   end

   // AXI4-Lite write path: address and data taken in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready   <= 1'b1;
         s_axi_wready    <= 1'b1;
         s_axi_bvalid    <= 1'b0;
         s_axi_bresp     <= 2'b00;
         aw_held_q       <= 1'b0;
         w_held_q        <= 1'b0;
         awaddr_q        <= 8'h00;
         wdata_q         <= 32'h00000000;
         wstrb_q         <= 4'h0;
         slave_state_q   <= `BCSI_ST_INIT;
         chop_req_q      <= 1'b0;
         amb_temp_q      <= `BCSI_RST_AMB_TEMP;
         therm_res_q     <= `BCSI_RST_THERM_RES;
         time_const_q    <= `BCSI_RST_TIME_CONST;
         irq_mask_q      <= {NC{1'b0}};
         irq_stat_q      <= {NC{1'b0}};
         params_restored <= 1'b0;
      end else begin
         params_restored <= 1'b0;
         if (s_axi_awvalid & s_axi_awready) begin
            awaddr_q      <= {s_axi_awaddr[7:2], 2'b00};
            aw_held_q     <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
            w_held_q     <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
         if (wr_go) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= 2'b00;
            case (awaddr_q)
               `BCSI_OFS_CTRL: begin
                  if (wstrb_q[0]) begin
                     slave_state_q <= wdata_q[`BCSI_CTRL_STATE_LSB +: `BCSI_CTRL_STATE_W];
                     chop_req_q    <= wdata_q[`BCSI_CTRL_CHOP_REQ];
                  end
               end
               `BCSI_OFS_IRQ_MASK: if (wstrb_q[0]) irq_mask_q <= wdata_q[NC-1:0];
               `BCSI_OFS_AMB_TEMP:   amb_temp_q   <= merge16(amb_temp_q, wdata_q, wstrb_q);
               `BCSI_OFS_THERM_RES:  therm_res_q  <= merge16(therm_res_q, wdata_q, wstrb_q);
               `BCSI_OFS_TIME_CONST: time_const_q <= merge16(time_const_q, wdata_q, wstrb_q);
               `BCSI_OFS_IRQ_STAT, `BCSI_OFS_RESTORE, `BCSI_OFS_COND,
               `BCSI_OFS_LAMPS, `BCSI_OFS_PD_STATUS: s_axi_bresp <= 2'b00;
               default: s_axi_bresp <= 2'b10;
            endcase
            if (restore_hit) begin
               amb_temp_q      <= `BCSI_RST_AMB_TEMP;
               therm_res_q     <= `BCSI_RST_THERM_RES;
               time_const_q    <= `BCSI_RST_TIME_CONST;
               params_restored <= 1'b1;
            end
         end
         // Sticky events: write one clears, a new event wins over the clear
         if (wr_go && awaddr_q == `BCSI_OFS_IRQ_STAT && wstrb_q[0])
            irq_stat_q <= (irq_stat_q & ~wdata_q[NC-1:0]) | events;
         else
            irq_stat_q <= irq_stat_q | events;
      end
   end

   // AXI4-Lite read path, one read at a time
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= 2'b00;
      end else begin
         if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= 2'b00;
            s_axi_rdata   <= 32'h00000000;
            case ({s_axi_araddr[7:2], 2'b00})
               `BCSI_OFS_CTRL:
                  s_axi_rdata <= {27'h0, chop_req_q, 1'b0, slave_state_q};
               `BCSI_OFS_COND:       s_axi_rdata <= {25'h0, cond_q};
               `BCSI_OFS_LAMPS:
                  s_axi_rdata <= {24'h0, lamp_error, lamp_chopper, lamp_res_warn, lamp_undervolt,
                                  lamp_board_temp, lamp_overvolt, lamp_supply_ok, lamp_run};
               `BCSI_OFS_IRQ_STAT:   s_axi_rdata <= {25'h0, irq_stat_q};
               `BCSI_OFS_IRQ_MASK:   s_axi_rdata <= {25'h0, irq_mask_q};
               `BCSI_OFS_RESTORE:    s_axi_rdata <= 32'h00000000;
               `BCSI_OFS_AMB_TEMP:   s_axi_rdata <= {16'h0, amb_temp_q};
               `BCSI_OFS_THERM_RES:  s_axi_rdata <= {16'h0, therm_res_q};
               `BCSI_OFS_TIME_CONST: s_axi_rdata <= {16'h0, time_const_q};
               // OP reports state 8 and counter 0
               `BCSI_OFS_PD_STATUS:
                  s_axi_rdata <= in_op ? {16'h0, `BCSI_PD_WCNT_OK, `BCSI_PD_STATE_OP} : 32'h00000000;
               default: s_axi_rresp <= 2'b10;
            endcase
         end
      end
   end

endmodule // bcsi_top

// ==== bench/bcsi_meas_model.sv ====
/*
 Model of the measurement side: drives the seven condition flags.
 Assumes the bench sets the wanted pattern in condition-register bit order.
*/
`timescale 1ns/1ps
module bcsi_meas_model (
   // Clock
   input  wire       aclk,
   // Wanted flag pattern
   input  wire [6:0] req,
   // Flags toward the block
   output reg        supply_high,
   output reg        supply_low,
   output reg        supply_absent,
   output reg        board_hot,
   output reg        current_squared_time_limit,
   output reg        resistor_hot,
   output reg        chopper_switched
);
   // Flags start quiet so the block sees no false event at power-up
   initial {chopper_switched, resistor_hot, current_squared_time_limit, board_hot,
            supply_absent, supply_low, supply_high} = 7'h00;
   // Flags move just after an edge, like sampled comparator outputs
   always @(posedge aclk) begin
      {chopper_switched, resistor_hot, current_squared_time_limit, board_hot,
       supply_absent, supply_low, supply_high} <= req;
   end
endmodule // bcsi_meas_model

// ==== bench/bcsi_top_asserts.sv ====
/*
 Port checker for bcsi_top: bus answers and lamp consistency.
 Assumes it is bound into bcsi_top and sees only its ports.
*/
`timescale 1ns/1ps
module bcsi_top_chk (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Bus handshakes
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   // Flag and lamps
   input wire chopper_switched,
   input wire lamp_run,
   input wire lamp_supply_ok,
   input wire lamp_overvolt,
   input wire lamp_board_temp,
   input wire lamp_undervolt,
   input wire lamp_res_warn,
   input wire lamp_chopper,
   input wire lamp_error,
   // Control outputs
   input wire chopper_drive,
   input wire pd_exchange_en,
   input wire params_restored,
   input wire irq
);
   // One clock domain; reset masks all but the reset check
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Reset must darken every lamp at the next edge
   AST_RESET_DARK: assert property (disable iff (1'b0) !aresetn |=>
      !(lamp_run | lamp_supply_ok | lamp_overvolt | lamp_board_temp | lamp_undervolt | lamp_res_warn |
      lamp_chopper | lamp_error)) else $error("lamp lit after reset");
   // Supply good never beside a fault lamp
   AST_SUPOK_ALONE: assert property (
      lamp_supply_ok |-> !(lamp_overvolt | lamp_undervolt | lamp_board_temp | lamp_error)) else $error("supply lamp with fault");
   // Error lamp always has its partner lamps
   AST_ERR_PAIRED: assert property (
      lamp_error |-> lamp_undervolt | (lamp_res_warn & lamp_overvolt)) else $error("error lamp alone");
   // Chopper lamp follows the resistor switch within the sync delay
   AST_CHOP_ON: assert property (
      $rose(chopper_switched) |-> ##[3:8] lamp_chopper) else $error("chopper lamp late on");
   AST_CHOP_OFF: assert property (
      $fell(chopper_switched) |-> ##[3:8] !lamp_chopper) else $error("chopper lamp late off");
   // Drive only in the state that exchanges process data
   AST_DRIVE_OP: assert property (
      chopper_drive |-> pd_exchange_en) else $error("drive outside operation");
   // Settled operation shows a steady run lamp
   AST_RUN_OP: assert property (
      pd_exchange_en [*4] |-> lamp_run) else $error("run lamp dark in operation");
   // Restore notice is a single-cycle pulse
   AST_RESTORE_PULSE: assert property (
      params_restored |=> !params_restored) else $error("restore pulse too long");
   // Bus answers two cycles after a write take, one cycle after a read take
   AST_WR_ANSWER: assert property (
      s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready |-> ##2 s_axi_bvalid) else $error("no write answer");
   AST_RD_ANSWER: assert property (
      s_axi_arvalid & s_axi_arready |=> s_axi_rvalid & !s_axi_arready) else $error("no read answer");
   AST_B_ONCE: assert property (
      s_axi_bvalid & s_axi_bready |=> !s_axi_bvalid) else $error("write answer repeated");
   // Main scenarios reached
   COV_RESTORE: cover property (params_restored);
   COV_ERR_UV: cover property (lamp_error & lamp_undervolt);
   COV_IRQ: cover property (irq);
endmodule // bcsi_top_chk

bind bcsi_top bcsi_top_chk u_chk (.*);

// ==== bench/bcsi_top_tb.sv ====
/*
 Self-checking bench for bcsi_top: bus tasks, state, lamp and event tests.
 Assumes a 125 MHz clock and a lamp tick shortened to 10 cycles.
*/
`timescale 1ns/1ps
`include "bcsi_defines.vh"
module bcsi_top_tb;
   // Tables: states, lit cycles per 400, parameter places and values
   localparam [14:0] STV = {`BCSI_ST_BOOT, `BCSI_ST_OP, `BCSI_ST_SAFEOP, `BCSI_ST_PREOP, `BCSI_ST_INIT};
   localparam [44:0] ONV = {9'h0C8, 9'h190, 9'h050, 9'h0C8, 9'h000};
   localparam [23:0] PAV = {`BCSI_OFS_TIME_CONST, `BCSI_OFS_THERM_RES, `BCSI_OFS_AMB_TEMP};
   localparam [47:0] DFV = {`BCSI_RST_TIME_CONST, `BCSI_RST_THERM_RES, `BCSI_RST_AMB_TEMP};
   localparam [47:0] NWV = {16'h0064, 16'h05DC, 16'h001E};
   // Bus drive and flag request
   reg         aclk = 1'b0;
   reg         aresetn = 1'b0;
   reg  [7:0]  awaddr = 8'h00;
   reg  [7:0]  araddr = 8'h00;
   reg  [31:0] wdata = 32'h0;
   reg         awvalid = 1'b0;
   reg         wvalid = 1'b0;
   reg         arvalid = 1'b0;
   reg  [3:0]  wstrb = 4'hF;
   reg  [6:0]  req = 7'h00;
   // Design answers
   wire        awready, wready, bvalid, arready, rvalid, drv, pde, rstd, irq;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata;
   wire [7:0]  lp;
   wire [6:0]  fl;
   // Bookkeeping
   integer     bad_count = 0;
   integer     cmp_count = 0;
   integer     i, n;
   reg  [31:0] rd;
   reg  [1:0]  rs;
   reg  [6:0]  f;
   reg  [7:0]  ex;

   bcsi_top #(.TICK_CYC(10)) uut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
      .supply_high(fl[0]), .supply_low(fl[1]), .supply_absent(fl[2]), .board_hot(fl[3]),
      .current_squared_time_limit(fl[4]), .resistor_hot(fl[5]), .chopper_switched(fl[6]),
      .lamp_run(lp[0]), .lamp_supply_ok(lp[1]), .lamp_overvolt(lp[2]), .lamp_board_temp(lp[3]),
      .lamp_undervolt(lp[4]), .lamp_res_warn(lp[5]), .lamp_chopper(lp[6]), .lamp_error(lp[7]),
      .chopper_drive(drv), .pd_exchange_en(pde), .params_restored(rstd), .irq(irq));

   bcsi_meas_model u_meas (
      .aclk(aclk), .req(req), .supply_high(fl[0]), .supply_low(fl[1]), .supply_absent(fl[2]),
      .board_hot(fl[3]), .current_squared_time_limit(fl[4]), .resistor_hot(fl[5]), .chopper_switched(fl[6]));

   // 8 ns clock
   always #4 aclk = ~aclk;

   // Verdict and stop
   task end_sim;
      begin
         $display("TB: %0d compares, %0d mismatches", cmp_count, bad_count);
         if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
         else $display("TB: FAIL");
         $finish;
      end
   endtask

   // Compare and count
   task chk(input [31:0] got, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
         end
      end
   endtask

   // One edge of a bounded wait; a hung bus ends the run
   task tick(inout integer k);
      begin
         @(posedge aclk);
         k = k + 1;
         if (k > 40) begin
            bad_count = bad_count + 1;
            $display("unexpected at %0t: bus gave no answer", $time);
            end_sim;
         end
      end
   endtask

   // Write: address and data offered together, each dropped once taken
   task wr(input [7:0] a, input [31:0] d, input [1:0] er);
      integer k;
      begin
         k = 0;
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         forever begin
            tick(k);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
               rs = bresp;
               break;
            end
         end
         chk({30'h0, rs}, {30'h0, er});
      end
   endtask

   // Read; data checked only when an OKAY answer is expected
   task rdr(input [7:0] a, input [31:0] exp, input [1:0] er);
      integer k;
      begin
         k = 0;
         araddr <= a;
         arvalid <= 1'b1;
         forever begin
            tick(k);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
               rd = rdata;
               rs = rresp;
               break;
            end
         end
         chk({30'h0, rs}, {30'h0, er});
         if (er == 2'h0) chk(rd, exp);
      end
   endtask

   initial begin
      repeat (2) @(posedge aclk);
      chk({24'h0, lp}, 32'h0);
      aresetn <= 1'b1;
      rdr(`BCSI_OFS_CTRL, {29'h0, `BCSI_ST_INIT}, 2'h0);
      // Defaults, then new values held
      for (i = 0; i < 3; i = i + 1) begin
         rdr(PAV[8*i +: 8], {16'h0, DFV[16*i +: 16]}, 2'h0);
         wr(PAV[8*i +: 8], {16'h0, NWV[16*i +: 16]}, 2'h0);
         rdr(PAV[8*i +: 8], {16'h0, NWV[16*i +: 16]}, 2'h0);
      end
      // A near miss must not restore
      wr(`BCSI_OFS_RESTORE, `BCSI_RESTORE_PAT ^ 32'h1, 2'h0);
      wstrb <= 4'h7;
      wr(`BCSI_OFS_RESTORE, `BCSI_RESTORE_PAT, 2'h0);
      wstrb <= 4'hF;
      chk({31'h0, rstd}, 32'h0);
      rdr(`BCSI_OFS_AMB_TEMP, {16'h0, NWV[15:0]}, 2'h0);
      wr(`BCSI_OFS_RESTORE, `BCSI_RESTORE_PAT, 2'h0);
      chk({31'h0, rstd}, 32'h1);
      for (i = 0; i < 3; i = i + 1) begin
         rdr(PAV[8*i +: 8], {16'h0, DFV[16*i +: 16]}, 2'h0);
      end
      $display("TB: test parameters done");
      // Each state with chopper request: lit cycles per 400, drive and status
      for (i = 0; i < 5; i = i + 1) begin
         wr(`BCSI_OFS_CTRL, {27'h0, 2'h2, STV[3*i +: 3]}, 2'h0);
         repeat (6) @(posedge aclk);
         n = 0;
         repeat (400) begin
            @(posedge aclk);
            n = n + lp[0];
         end
         chk(n, {23'h0, ONV[9*i +: 9]});
         chk({30'h0, drv, pde}, (STV[3*i +: 3] == `BCSI_ST_OP) ? 32'h3 : 32'h0);
         rdr(`BCSI_OFS_PD_STATUS, (STV[3*i +: 3] == `BCSI_ST_OP) ?
             {16'h0, `BCSI_PD_WCNT_OK, `BCSI_PD_STATE_OP} : 32'h0, 2'h0);
      end
      wr(`BCSI_OFS_CTRL, {29'h0, `BCSI_ST_INIT}, 2'h0);
      $display("TB: test states done");
      // One flag at a time, then none
      for (i = 0; i < 8; i = i + 1) begin
         f = (i < 7) ? (7'h01 << i) : 7'h00;
         req <= f;
         repeat (10) @(posedge aclk);
         ex = {f[2] | f[5], f[6], f[4] | f[5], f[1] | f[2], f[3], f[0] | f[5], ~(|{f[5], f[3:0]}), 1'b0};
         chk({24'h0, lp}, {24'h0, ex});
         rdr(`BCSI_OFS_COND, {25'h0, f}, 2'h0);
         rdr(`BCSI_OFS_LAMPS, {24'h0, ex}, 2'h0);
      end
      // Lamp register ignores writes
      wr(`BCSI_OFS_LAMPS, 32'hFFFFFFFF, 2'h0);
      rdr(`BCSI_OFS_LAMPS, 32'h2, 2'h0);
      $display("TB: test lamps done");
      // Every flag rose once: all events sticky, masked off
      rdr(`BCSI_OFS_IRQ_STAT, 32'h7F, 2'h0);
      chk({31'h0, irq}, 32'h0);
      wr(`BCSI_OFS_IRQ_MASK, 32'h1, 2'h0);
      repeat (2) @(posedge aclk);
      chk({31'h0, irq}, 32'h1);
      wr(`BCSI_OFS_IRQ_STAT, 32'h1, 2'h0);
      repeat (2) @(posedge aclk);
      chk({31'h0, irq}, 32'h0);
      rdr(`BCSI_OFS_IRQ_STAT, 32'h7E, 2'h0);
      $display("TB: test interrupt done");
      // Unmapped place is refused
      wr(8'h80, 32'h1, 2'h2);
      rdr(8'h80, 32'h0, 2'h2);
      $display("TB: test unmapped done");
      end_sim;
   end
endmodule // bcsi_top_tb
